// ### hdl/qaw_pkg.sv
// Purpose: shared constants and types of the question-answer watchdog
// Assumes: 125 MHz system clock, APB register access
// Notes:   watchdog tick is derived from the system clock
`default_nettype none
package qaw_pkg;
    // register byte addresses
    localparam logic [7:0] QAW_ADDR_QUESTION_LOW  = 8'h00;
    localparam logic [7:0] QAW_ADDR_QUESTION_HIGH = 8'h04;
    localparam logic [7:0] QAW_ADDR_RESP_TIME     = 8'h08;
    localparam logic [7:0] QAW_ADDR_ANSWER        = 8'h0C;
    localparam logic [7:0] QAW_ADDR_CONTROL       = 8'h10;
    localparam logic [7:0] QAW_ADDR_STATUS        = 8'h14;
    // reset values and counter limits
    localparam logic [2:0] QAW_EC_INIT        = 3'h6;
    localparam logic [2:0] QAW_EC_ALARM_LIMIT = 3'h4;
    localparam logic [2:0] QAW_CNT_MAX        = 3'h7;
    localparam logic [7:0] QAW_RESP_TIME_INIT = 8'h3F;
    localparam logic [1:0] QAW_BYTE_CNT_INIT  = 2'h3;
    // timing: watchdog oscillator 64 kHz, divide 101, window 8 units
    localparam int QAW_SYS_HZ      = 125_000_000;
    localparam int QAW_OSC_HZ      = 64_000;
    localparam int QAW_OSC_DIV     = QAW_SYS_HZ / QAW_OSC_HZ;
    localparam int QAW_UNIT_TICKS  = 101;
    localparam int QAW_WINDOW_UNITS = 8;
    // sequencer states, gray along the usual path
    typedef enum logic [1:0] {
        QAW_ST_WAIT   = 2'b00,
        QAW_ST_WINDOW = 2'b01
    } qaw_state_e;
    // counters of the monitoring sequence, carried together
    typedef struct packed {
        logic [2:0] error_count;
        logic [2:0] shutdown_count;
        logic [2:0] reset_count;
        logic       shutdown_signal;
        logic       reset_request;
    } qaw_mon_s;
endpackage
`default_nettype wire

// ### hdl/qaw_watchdog.sv
// Purpose: question-answer watchdog with APB register access
// Assumes: rst_i is the undervoltage reset; soft_reset_i is synchronous
// Notes:   expected answer bytes follow the documented xor equations
//
// The APB register port and the address map were left to the implementer.
`default_nettype none
module qaw_watchdog #(
    parameter int OSC_DIV = qaw_pkg::QAW_OSC_DIV
) (
    input  wire logic        clock_i,         // system clock
    input  wire logic        rst_i,           // undervoltage reset
    input  wire logic        soft_reset_i,    // soft reset event pulse
    input  wire logic        sys_reset_i,     // system reset level, pin
    input  wire logic        power_latch_i,   // after-run power latch
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             alarm_pin_o,     // drive-low value, always 0
    output logic             alarm_pin_oe_o,  // high while pulling low
    output logic             shutdown_signal_o,
    output logic             power_off_o,     // relay and regulators off
    output logic             watchdog_reset_request_o
);
    initial begin
        if (OSC_DIV < 1) $error("OSC_DIV must be at least 1");
    end

    // three-stage sync of the reset pin
    logic [2:0] sys_rst_sync_q, sys_rst_sync_d;
    logic       sys_rst_seen_q, sys_rst_seen_d;
    always_comb begin
        sys_rst_sync_d = {sys_rst_sync_q[1:0], sys_reset_i};
        // a change counts once stages two and three agree
        sys_rst_seen_d = (sys_rst_sync_q[2] == sys_rst_sync_q[1])
                       ? sys_rst_sync_q[2] : sys_rst_seen_q;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sys_rst_sync_q <= 3'h0;
            sys_rst_seen_q <= 1'b0;
        end else begin
            sys_rst_sync_q <= sys_rst_sync_d;
            sys_rst_seen_q <= sys_rst_seen_d;
        end
    end

    // timebase: oscillator tick, then response-time unit
    logic [15:0] osc_cnt_q, osc_cnt_d;
    logic [6:0]  unit_cnt_q, unit_cnt_d;
    logic        unit_tick;
    always_comb begin
        osc_cnt_d  = osc_cnt_q + 16'h0001;
        unit_cnt_d = unit_cnt_q;
        unit_tick  = 1'b0;
        if (osc_cnt_q == 16'(OSC_DIV - 1)) begin
            osc_cnt_d = 16'h0000;
            if (unit_cnt_q == 7'(qaw_pkg::QAW_UNIT_TICKS - 1)) begin
                unit_cnt_d = 7'h00;
                unit_tick  = 1'b1;
            end else begin
                unit_cnt_d = unit_cnt_q + 7'h01;
            end
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            osc_cnt_q  <= 16'h0000;
            unit_cnt_q <= 7'h00;
        end else begin
            osc_cnt_q  <= osc_cnt_d;
            unit_cnt_q <= unit_cnt_d;
        end
    end

    // apb decode, zero wait states
    logic apb_wr, apb_rd;
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;

    // question generation state
    logic [3:0] qcount_q, qcount_d;   // question counter
    logic [3:0] chain_q, chain_d;     // pseudo-random chain
    logic [3:0] question;
    logic       chain_fb;
    always_comb begin
        question[0] = chain_q[1] ^ qcount_q[1];
        question[1] = chain_q[3] ^ qcount_q[3];
        question[2] = chain_q[0] ^ qcount_q[0];
        question[3] = chain_q[2] ^ qcount_q[2];
        // zero term escapes the all-zero lockup
        chain_fb = (chain_q[3] ^ chain_q[2]) | (chain_q == 4'h0);
    end

    // expected byte from question and byte count
    logic [1:0] byte_cnt_q, byte_cnt_d;
    logic [7:0] expect_byte;
    always_comb begin
        expect_byte[7] = question[2] ^ byte_cnt_q[0];
        expect_byte[6] = question[0] ^ byte_cnt_q[0];
        expect_byte[5] = question[3] ^ byte_cnt_q[0];
        expect_byte[4] = question[1] ^ byte_cnt_q[0];
        expect_byte[3] = question[2] ^ question[0] ^ question[3]
                       ^ byte_cnt_q[1];
        expect_byte[2] = question[0] ^ question[3] ^ question[1]
                       ^ byte_cnt_q[1];
        expect_byte[1] = question[2] ^ question[0] ^ question[1]
                       ^ byte_cnt_q[1];
        expect_byte[0] = byte_cnt_q[1] ^ question[3] ^ question[0];
    end

    // sequencer and monitoring state
    qaw_pkg::qaw_state_e state_q, state_d;
    logic [7:0]  resp_time_q, resp_time_d;
    logic [7:0]  unit_left_q, unit_left_d;   // units left in phase
    logic        ans_err_q, ans_err_d;       // answer error flag
    logic        last_ok_q, last_ok_d;       // last compare result
    logic        reset_en_q, reset_en_d;     // reset enable bit
    qaw_pkg::qaw_mon_s mon_q, mon_d;
    logic        alarm_q, alarm_d;           // alarm_internal
    logic        ans_wr, last_byte, time_wr, expire;
    logic        good, overflow, byte_bad;
    always_comb begin
        state_d     = state_q;
        resp_time_d = resp_time_q;
        unit_left_d = unit_left_q;
        ans_err_d   = ans_err_q;
        last_ok_d   = last_ok_q;
        reset_en_d  = reset_en_q;
        mon_d       = mon_q;
        qcount_d    = qcount_q;
        chain_d     = chain_q;
        byte_cnt_d  = byte_cnt_q;
        good        = 1'b0;
        overflow    = 1'b0;
        ans_wr      = apb_wr && paddr == qaw_pkg::QAW_ADDR_ANSWER;
        time_wr     = apb_wr && paddr == qaw_pkg::QAW_ADDR_RESP_TIME;
        last_byte   = ans_wr && byte_cnt_q == 2'h0;
        byte_bad    = pwdata[7:0] != expect_byte;
        expire      = unit_tick && state_q == qaw_pkg::QAW_ST_WINDOW
                      && unit_left_q == 8'h00;
        if (apb_wr && paddr == qaw_pkg::QAW_ADDR_CONTROL) begin
            reset_en_d = pwdata[0];
        end
        // phase timing advances on unit ticks
        if (unit_tick) begin
            if (unit_left_q != 8'h00) begin
                unit_left_d = unit_left_q - 8'h01;
            end else if (state_q == qaw_pkg::QAW_ST_WAIT) begin
                state_d     = qaw_pkg::QAW_ST_WINDOW;
                unit_left_d = 8'(qaw_pkg::QAW_WINDOW_UNITS - 1);
            end
        end
        // early bytes are checked whatever the phase
        if (ans_wr && !last_byte) begin
            byte_cnt_d = byte_cnt_q - 2'h1;
            ans_err_d  = ans_err_q | byte_bad;
        end
        // a sequencer run: last byte, time write or window end
        if (last_byte || time_wr || expire) begin
            if (last_byte) begin
                // only the last byte is judged for timing
                good = !(ans_err_q | byte_bad)
                     && state_q == qaw_pkg::QAW_ST_WINDOW
                     && resp_time_q != 8'h00;
                last_ok_d = good;
            end
            if (time_wr) begin
                resp_time_d = pwdata[7:0];
            end
            if (good) begin
                if (mon_q.error_count != 3'h0) begin
                    mon_d.error_count = mon_q.error_count - 3'h1;
                end
                qcount_d = qcount_q + 4'h1;
                if (qcount_q == 4'hF) begin
                    chain_d = {chain_q[2:0], chain_fb};
                end
            end else if (mon_q.error_count == qaw_pkg::QAW_CNT_MAX) begin
                overflow          = 1'b1;
                mon_d.error_count = qaw_pkg::QAW_EC_INIT;
            end else begin
                mon_d.error_count = mon_q.error_count + 3'h1;
            end
            // question unchanged unless good, so time runs keep it
            byte_cnt_d  = qaw_pkg::QAW_BYTE_CNT_INIT;
            ans_err_d   = 1'b0;
            state_d     = qaw_pkg::QAW_ST_WAIT;
            unit_left_d = time_wr ? pwdata[7:0] : resp_time_q;
        end
        mon_d.reset_request = 1'b0;
        if (overflow && reset_en_q) begin
            if (mon_q.reset_count != qaw_pkg::QAW_CNT_MAX) begin
                mon_d.reset_count   = mon_q.reset_count + 3'h1;
                mon_d.reset_request = 1'b1;
            end
        end
        // shutdown counter and signal
        if ((overflow || (soft_reset_i && alarm_q))) begin
            if (mon_q.shutdown_count == qaw_pkg::QAW_CNT_MAX) begin
                mon_d.shutdown_signal = 1'b1;
            end else begin
                mon_d.shutdown_count = mon_q.shutdown_count + 3'h1;
            end
        end
        alarm_d = mon_d.error_count > qaw_pkg::QAW_EC_ALARM_LIMIT;
        if (!alarm_q) begin
            mon_d.shutdown_count  = 3'h0;
            mon_d.shutdown_signal = 1'b0;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q     <= qaw_pkg::QAW_ST_WAIT;
            resp_time_q <= qaw_pkg::QAW_RESP_TIME_INIT;
            unit_left_q <= qaw_pkg::QAW_RESP_TIME_INIT;
            ans_err_q   <= 1'b0;
            last_ok_q   <= 1'b0;
            reset_en_q  <= 1'b0;
            mon_q       <= '{error_count: qaw_pkg::QAW_EC_INIT,
                             default: '0};
            alarm_q     <= 1'b1;
            qcount_q    <= 4'h0;
            chain_q     <= 4'h0;
            byte_cnt_q  <= qaw_pkg::QAW_BYTE_CNT_INIT;
        end else begin
            state_q     <= state_d;
            resp_time_q <= resp_time_d;
            unit_left_q <= unit_left_d;
            ans_err_q   <= ans_err_d;
            last_ok_q   <= last_ok_d;
            reset_en_q  <= reset_en_d;
            mon_q       <= mon_d;
            alarm_q     <= alarm_d;
            qcount_q    <= qcount_d;
            chain_q     <= chain_d;
            byte_cnt_q  <= byte_cnt_d;
        end
    end

    // registered outputs and read data
    logic [31:0] rdata_d;
    always_comb begin
        case (paddr)
            qaw_pkg::QAW_ADDR_QUESTION_LOW:  rdata_d = {28'h0, question};
            qaw_pkg::QAW_ADDR_QUESTION_HIGH: rdata_d = {31'h0, last_ok_q};
            qaw_pkg::QAW_ADDR_RESP_TIME:     rdata_d = {24'h0, resp_time_q};
            qaw_pkg::QAW_ADDR_CONTROL:       rdata_d = {31'h0, reset_en_q};
            qaw_pkg::QAW_ADDR_STATUS:
                rdata_d = {19'h0, byte_cnt_q, alarm_q, mon_q.shutdown_signal,
                           mon_q.reset_count, mon_q.shutdown_count,
                           mon_q.error_count};
            default:                         rdata_d = 32'h0;
        endcase
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata                   <= 32'h0;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
            alarm_pin_o              <= 1'b0;
            alarm_pin_oe_o           <= 1'b1;
            shutdown_signal_o        <= 1'b0;
            power_off_o              <= 1'b0;
            watchdog_reset_request_o <= 1'b0;
        end else begin
            // answer one cycle after setup, in the access phase
            pready  <= psel & ~penable;
            prdata  <= rdata_d;
            pslverr <= psel & ~penable & (paddr[1:0] != 2'b00 ||
                       paddr > qaw_pkg::QAW_ADDR_STATUS);
            alarm_pin_o    <= 1'b0;
            alarm_pin_oe_o <= alarm_d | sys_rst_seen_q;
            shutdown_signal_o <= mon_d.shutdown_signal;
            power_off_o    <= mon_d.shutdown_signal & power_latch_i;
            watchdog_reset_request_o <= mon_d.reset_request;
        end
    end

    // alarm follows error counter
    alarm_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
        alarm_q == (mon_q.error_count > qaw_pkg::QAW_EC_ALARM_LIMIT))
        else $error("alarm disagrees with error counter");
    sequence good_answer_s;
        last_byte && good;
    endsequence
    good_dec_a: assert property (@(posedge clock_i) disable iff (rst_i)
        good_answer_s and (mon_q.error_count != 3'h0) |=>
        mon_q.error_count == $past(mon_q.error_count) - 3'h1)
        else $error("good answer did not decrement");
    zero_time_a: assert property (@(posedge clock_i) disable iff (rst_i)
        last_byte && resp_time_q == 8'h00 |-> !good)
        else $error("zero response time accepted");
    question_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (time_wr || expire) && !last_byte |=> $stable(qcount_q)
        && $stable(chain_q))
        else $error("question moved on timing run");
    ovf_reload_a: assert property (@(posedge clock_i) disable iff (rst_i)
        overflow |=> mon_q.error_count == qaw_pkg::QAW_EC_INIT)
        else $error("overflow did not reload counter");
    shut_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !alarm_q |=> mon_q.shutdown_count == 3'h0 && !mon_q.shutdown_signal)
        else $error("shutdown state not cleared");
    reset_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !reset_en_q |=> ##1 !watchdog_reset_request_o)
        else $error("reset requested while disabled");
    chain_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
        good && qcount_q == 4'hF |=> chain_q == {$past(chain_q[2:0]),
        $past(chain_fb)})
        else $error("chain did not step on wrap");
endmodule
`default_nettype wire

// ### tb/qaw_ctrl_model.sv
// Purpose: controller model working the watchdog registers over APB
// Assumes: caller starts one transfer at a time; design answers at will
// Notes:   answer bytes are built from the comparator xor equations
`default_nettype none
module qaw_ctrl_model (
    input  wire logic        clock_i,  // system clock
    output logic             psel,     // apb select
    output logic             penable,  // apb access phase
    output logic             pwrite,   // apb direction
    output logic      [7:0]  paddr,    // apb byte address
    output logic      [31:0] pwdata,   // apb write data
    input  wire logic [31:0] prdata,   // apb read data
    input  wire logic        pready,   // apb ready
    input  wire logic        pslverr   // apb error
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // one transfer; holds everything until pready is seen high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale data would hide a slave sampling late
        pwdata <= ~d;
    endtask
    // byte expected for question q at byte count c
    function automatic logic [7:0] ans_byte(input logic [3:0] q,
                                            input logic [1:0] c);
        return {q[2] ^ c[0], q[0] ^ c[0], q[3] ^ c[0], q[1] ^ c[0],
                q[2] ^ q[0] ^ q[3] ^ c[1], q[0] ^ q[3] ^ q[1] ^ c[1],
                q[2] ^ q[0] ^ q[1] ^ c[1], c[1] ^ q[3] ^ q[0]};
    endfunction
    // whole answer, first byte first; gap delays only the last byte
    task automatic send_answer(input logic [3:0] q, input int gap,
                               input logic [7:0] flip);
        logic [31:0] r;
        logic        e;
        for (int c = 3; c > 0; c--) begin
            xfer(qaw_pkg::QAW_ADDR_ANSWER, 1'b1,
                 {24'h00_0000, ans_byte(q, 2'(c))}, r, e);
        end
        repeat (gap) @(posedge clock_i);
        xfer(qaw_pkg::QAW_ADDR_ANSWER, 1'b1,
             {24'h00_0000, ans_byte(q, 2'b00) ^ flip}, r, e);
    endtask
endmodule
`default_nettype wire

// ### tb/test_question_answer_watchdog.sv
// Purpose: self-checking bench of the question-answer watchdog
// Assumes: OSC_DIV of 1, so one time unit is 101 clocks
// Notes:   question counter, chain and error counter are modelled here
`default_nettype none
module test_question_answer_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, rst_i, soft_reset_i, sys_reset_i;
    logic        power_latch_i, psel, penable, pwrite;
    logic [7:0]  paddr;       // apb address
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, alarm_pin_o, alarm_pin_oe_o, e;
    logic        shutdown_signal_o, power_off_o, watchdog_reset_request_o;
    logic [3:0]  mc, zc;      // model chain and question counter
    logic [2:0]  ec, sd;      // model error and shutdown counters
    int          errors = 0, checked = 0, pulses = 0;
    qaw_watchdog #(.OSC_DIV(1)) i_qaw_watchdog (.clock_i(clock_i),
        .rst_i(rst_i), .soft_reset_i(soft_reset_i),
        .sys_reset_i(sys_reset_i), .power_latch_i(power_latch_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_pin_o(alarm_pin_o),
        .alarm_pin_oe_o(alarm_pin_oe_o),
        .shutdown_signal_o(shutdown_signal_o), .power_off_o(power_off_o),
        .watchdog_reset_request_o(watchdog_reset_request_o));
    qaw_ctrl_model i_qaw_ctrl_model (.clock_i(clock_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // 125 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // hang guard, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clock_i);
        errors++;
        give_verdict();
    end
    // request pulses last one cycle, so count them as they pass
    always @(posedge clock_i) begin
        if (watchdog_reset_request_o === 1'b1) pulses++;
    end
    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        i_qaw_ctrl_model.xfer(a, 1'b0, 32'h0000_0000, r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_qaw_ctrl_model.xfer(a, 1'b1, v, d, e);
    endtask
    // question bits mix chain and counter bits
    function automatic logic [3:0] exp_q(input logic [3:0] m, z);
        return {m[2] ^ z[2], m[0] ^ z[0], m[3] ^ z[3], m[1] ^ z[1]};
    endfunction
    // baseline after events whose error count effect is left open
    task automatic rd_ec();
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        ec = d[2:0];
    endtask
    task automatic expect_all();
        rd(qaw_pkg::QAW_ADDR_QUESTION_LOW, d);
        check(d, {28'h000_0000, exp_q(mc, zc)});
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({29'h0, d[2:0]}, {29'h0, ec});
        check({29'h0, d[5:3]}, {29'h0, sd});
        check({31'h0, alarm_pin_oe_o}, {31'h0, ec > 3'h4});
    endtask
    // correct answer landing inside the window
    task automatic good();
        i_qaw_ctrl_model.send_answer(exp_q(mc, zc), 340, 8'h00);
        repeat (4) @(posedge clock_i);
        if (ec != 3'h0) ec--;
        zc++;
        if (zc == 4'h0) mc = {mc[2:0], (mc[3] ^ mc[2]) | (mc == 4'h0)};
        if (ec <= 3'h4) sd = 3'h0;
        expect_all();
    endtask
    // wrong value or early last byte; question must stay
    task automatic bad(input int gap, input logic [7:0] flip);
        i_qaw_ctrl_model.send_answer(exp_q(mc, zc), gap, flip);
        repeat (4) @(posedge clock_i);
        if (ec == 3'h7) begin
            ec = qaw_pkg::QAW_EC_INIT;
            if (sd != 3'h7) sd++;
        end else begin
            ec++;
        end
        if (ec <= 3'h4) sd = 3'h0;
        expect_all();
    endtask
    task automatic soft_pulse();
        soft_reset_i <= 1'b1;
        @(posedge clock_i);
        soft_reset_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd_ec();
    endtask
    task automatic power_on();
        mc = 4'h0;
        zc = 4'h0;
        ec = qaw_pkg::QAW_EC_INIT;
        sd = 3'h0;
    endtask
    // main sequence
    initial begin
        rst_i = 1'b1;
        soft_reset_i = 1'b0;
        sys_reset_i = 1'b0;
        power_latch_i = 1'b0;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        power_on();
        expect_all();
        check({31'h0, alarm_pin_o}, 32'h0000_0000);
        rd(qaw_pkg::QAW_ADDR_RESP_TIME, d);
        check(d, 32'h0000_003F);
        rd(8'h18, d);
        check({31'h0, e}, 32'h0000_0001);
        wr(qaw_pkg::QAW_ADDR_RESP_TIME, 32'h0000_0001);
        rd_ec();
        repeat (16) good();
        rd(qaw_pkg::QAW_ADDR_QUESTION_HIGH, d);
        check({31'h0, d[0]}, 32'h0000_0001);
        wr(qaw_pkg::QAW_ADDR_ANSWER, 32'h0000_00FF);
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({30'h0, d[12:11]}, 32'h0000_0002);
        // finish the stray answer so the byte counter is back in step
        repeat (3) wr(qaw_pkg::QAW_ADDR_ANSWER, 32'h0000_0000);
        rd_ec();
        bad(340, 8'h01);
        rd(qaw_pkg::QAW_ADDR_QUESTION_HIGH, d);
        check({31'h0, d[0]}, 32'h0000_0000);
        bad(0, 8'h00);
        sys_reset_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check({31'h0, alarm_pin_oe_o}, 32'h0000_0001);
        sys_reset_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        check({31'h0, alarm_pin_oe_o}, 32'h0000_0000);
        while (sd == 3'h0) bad(0, 8'h00);
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({29'h0, d[8:6]}, 32'h0000_0000);
        check(32'(pulses), 32'h0000_0000);
        wr(qaw_pkg::QAW_ADDR_CONTROL, 32'h0000_0001);
        while (sd == 3'h1) bad(0, 8'h00);
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({29'h0, d[8:6]}, 32'h0000_0001);
        check(32'(pulses), 32'h0000_0001);
        // soft resets while alarmed step the shutdown count to the top
        while (sd != 3'h7) begin
            soft_pulse();
            sd++;
            check({29'h0, d[5:3]}, {29'h0, sd});
        end
        soft_pulse();
        check({31'h0, d[9]}, 32'h0000_0001);
        check({29'h0, d[5:3]}, 32'h0000_0007);
        check({31'h0, power_off_o}, 32'h0000_0000);
        power_latch_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check({31'h0, power_off_o}, 32'h0000_0001);
        power_latch_i <= 1'b0;
        wr(qaw_pkg::QAW_ADDR_RESP_TIME, 32'h0000_0001);
        rd_ec();
        while (ec > 3'h4) good();
        check({31'h0, shutdown_signal_o}, 32'h0000_0000);
        // zero response time costs a point even for a good answer
        wr(qaw_pkg::QAW_ADDR_RESP_TIME, 32'h0000_0000);
        rd_ec();
        i_qaw_ctrl_model.send_answer(exp_q(mc, zc), 340, 8'h00);
        repeat (4) @(posedge clock_i);
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({29'h0, d[2:0]}, {29'h0, ec + 3'h1});
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        power_on();
        expect_all();
        rd(qaw_pkg::QAW_ADDR_STATUS, d);
        check({29'h0, d[8:6]}, 32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
